//--- design/bta_defs.svh
// Constants for branch target addressing: offsets, field positions,
// reset values and decimal-adjust limits.
// Assumes inclusion by its bare name; definitions only.
`ifndef BTA_DEFS_SVH
`define BTA_DEFS_SVH
`define BTA_PC_W        16
`define BTA_RESET_PC    16'h0000
`define BTA_TBL_BASE    16'h0040
`define BTA_TBL_LAST    16'h007f
`define BTA_FAR_BASE    16'h0800
`define BTA_FAR_LAST    16'h0fff
`define BTA_FAR_W       11
`define BTA_DISP_W      8
`define BTA_LEN_W       3
`define BTA_NIB_LIM     4'h9
`define BTA_BCD_LIM     8'h99
`define BTA_ADJ_LO      8'h06
`define BTA_ADJ_HI      8'h60
`define BTA_DIV_ZERO_Q  16'hffff
`endif

//--- design/bta_pkg.sv
// Types for branch target addressing and implied accumulator operations.
// Assumes bta_defs.svh is on the include path.
`include "bta_defs.svh"
package bta_pkg;

  // Branch addressing form of the instruction being retired
  typedef enum logic [2:0] {
    BTA_SEQ  = 3'h0,
    BTA_REL  = 3'h1,
    BTA_LONG = 3'h2,
    BTA_FAR  = 3'h3,
    BTA_TBL  = 3'h4,
    BTA_REG  = 3'h5
  } bta_kind_e;

  // Gray along idle, low byte, high byte
  typedef enum logic [1:0] {
    BTA_IDLE  = 2'b00,
    BTA_RD_LO = 2'b01,
    BTA_RD_HI = 2'b11
  } bta_state_e;

  // Implied accumulator operations
  typedef enum logic [2:0] {
    BTA_OP_MUL      = 3'h0,
    BTA_OP_DIV      = 3'h1,
    BTA_OP_ADJ_ADD  = 3'h2,
    BTA_OP_ADJ_SUB  = 3'h3,
    BTA_OP_DIG_LEFT = 3'h4,
    BTA_OP_DIG_RGHT = 3'h5
  } bta_op_e;

  // Decoded branch request
  typedef struct packed {
    logic                     valid;
    bta_kind_e                kind;
    logic [`BTA_LEN_W-1:0]    len;
    logic [`BTA_DISP_W-1:0]   relative_displacement;
    logic [`BTA_PC_W-1:0]     imm;
    logic [`BTA_FAR_W-1:0]    short_call_field;
    logic [7:0]               opcode;
    logic [`BTA_PC_W-1:0]     accumulator_pair;
  } bta_req_s;

  // Branch unit state
  typedef struct packed {
    bta_state_e               state;
    logic [`BTA_PC_W-1:0]     pc;
    logic                     pc_load;
    logic [`BTA_PC_W-1:0]     tbl_addr;
    logic [7:0]               lo_byte;
  } bta_core_s;

  // Implied operation request; pair is {A, X}
  typedef struct packed {
    logic                     valid;
    bta_op_e                  op;
    logic [`BTA_PC_W-1:0]     accumulator_pair;
    logic [7:0]               divisor;
    logic [7:0]               mem_byte;
    logic                     cy;
    logic                     ac;
  } bta_iop_s;

  // Implied operation result, also the whole state of that unit
  typedef struct packed {
    logic                     valid;
    logic [`BTA_PC_W-1:0]     accumulator_pair;
    logic [7:0]               aux;
    logic                     cy;
  } bta_ires_s;

endpackage : bta_pkg

//--- design/bta_implied.sv
// Implied accumulator unit: multiply, word divide, decimal adjust,
// digit rotate, all working on A or the accumulator pair.
// Assumes one request per cycle; result registered one cycle later.
`timescale 1ns/1ns
`include "bta_defs.svh"
module bta_implied (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire bta_pkg::bta_iop_s   iop,
  output bta_pkg::bta_ires_s       ires
);

  bta_pkg::bta_ires_s s;
  bta_pkg::bta_ires_s next_s;

  // One result per request; aux is remainder or new memory byte
  always_comb begin
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] t;
    a = iop.accumulator_pair[15:8];
    x = iop.accumulator_pair[7:0];
    t = a;
    next_s = s;
    next_s.valid = iop.valid;
    if (iop.valid) begin
      next_s.cy = iop.cy;
      next_s.aux = iop.mem_byte;
      next_s.accumulator_pair = iop.accumulator_pair;
      case (iop.op)
        bta_pkg::BTA_OP_MUL: begin
          next_s.accumulator_pair = a * x;
        end
        bta_pkg::BTA_OP_DIV: begin
          // Zero divisor gives all-ones quotient rather than trapping
          if (iop.divisor == 8'h00) begin
            next_s.accumulator_pair = `BTA_DIV_ZERO_Q;
            next_s.aux = x;
          end else begin
            next_s.accumulator_pair = iop.accumulator_pair / iop.divisor;
            next_s.aux = 8'(iop.accumulator_pair % iop.divisor);
          end
        end
        bta_pkg::BTA_OP_ADJ_ADD: begin
          if (a[3:0] > `BTA_NIB_LIM || iop.ac) t = t + `BTA_ADJ_LO;
          if (a > `BTA_BCD_LIM || iop.cy) begin
            t = t + `BTA_ADJ_HI;
            next_s.cy = 1'b1;
          end
          next_s.accumulator_pair = {t, x};
        end
        bta_pkg::BTA_OP_ADJ_SUB: begin
          if (iop.ac) t = t - `BTA_ADJ_LO;
          if (iop.cy) t = t - `BTA_ADJ_HI;
          next_s.accumulator_pair = {t, x};
        end
        bta_pkg::BTA_OP_DIG_LEFT: begin
          next_s.accumulator_pair = {a[7:4], iop.mem_byte[7:4], x};
          next_s.aux = {iop.mem_byte[3:0], a[3:0]};
        end
        bta_pkg::BTA_OP_DIG_RGHT: begin
          next_s.accumulator_pair = {a[7:4], iop.mem_byte[3:0], x};
          next_s.aux = {a[3:0], iop.mem_byte[7:4]};
        end
        default: begin
          next_s.valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) s <= '0;
    else s <= next_s;
  end

  assign ires = s;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_mul_product: assert property (iop.valid && iop.op == bta_pkg::BTA_OP_MUL |=>
    ires.valid && ires.accumulator_pair == $past(iop.accumulator_pair[15:8]) * $past(iop.accumulator_pair[7:0]))
    else $error("multiply product wrong");
  a_div_quotient: assert property (iop.valid && iop.op == bta_pkg::BTA_OP_DIV && iop.divisor != 8'h00 |=>
    17'(ires.accumulator_pair * $past(iop.divisor)) + ires.aux == {1'b0, $past(iop.accumulator_pair)})
    else $error("divide quotient wrong");
  a_adj_keep: assert property (iop.valid && iop.op == bta_pkg::BTA_OP_ADJ_ADD && !iop.ac && !iop.cy
    && iop.accumulator_pair[11:8] <= `BTA_NIB_LIM && iop.accumulator_pair[15:8] <= `BTA_BCD_LIM
    |=> ires.accumulator_pair == $past(iop.accumulator_pair) && !ires.cy)
    else $error("decimal adjust altered valid bcd");
  a_digit_left: assert property (iop.valid && iop.op == bta_pkg::BTA_OP_DIG_LEFT |=>
    ires.accumulator_pair[11:8] == $past(iop.mem_byte[7:4]) && ires.aux[3:0] == $past(iop.accumulator_pair[11:8]))
    else $error("digit rotate left wrong");

  c_div_zero: cover property (iop.valid && iop.op == bta_pkg::BTA_OP_DIV && iop.divisor == 8'h00);

endmodule : bta_implied

//--- design/bta_core.sv
// Branch target addressing unit: next program counter for sequential,
// relative, immediate, table indirect and register branch forms, plus
// the implied accumulator unit.
// Assumes decode presents one request while req_ready is high and that
// memory answers a table read with mem_rvalid while mem_rd is held.
// Inputs are taken as synchronous to clk; every flop runs each edge.
//
// Operation
// - Sequential fetch adds instruction length to PC.
// - Relative target is next address plus displacement.
// - Displacement signed, bit 7 sign, -128..+127.
// - Short branch and conditional branches use relative.
// - Long call/branch load full 16-bit immediate.
// - Fixed-area call lands in 0800H to 0FFFH.
// - Table call index is opcode bits 1-5.
// - Call table lives at 40H to 7FH.
// - Register jump copies accumulator pair into PC.
// - Multiply takes A, writes product to pair.
// - Word divide reads and writes accumulator pair.
// - Decimal adjust works on A.
// - Digit rotates hold digit data in A.
// - Multiply is A times X, 16-bit result.
`timescale 1ns/1ns
`include "bta_defs.svh"
module bta_core #(
  parameter int unsigned              PC_W     = `BTA_PC_W,
  parameter logic [`BTA_PC_W-1:0]     RESET_PC = `BTA_RESET_PC
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire bta_pkg::bta_req_s      req,
  output logic                        req_ready,
  output logic [`BTA_PC_W-1:0]        pc,
  output logic                        pc_load,
  output logic                        mem_rd,
  output logic [`BTA_PC_W-1:0]        mem_addr,
  input  wire logic [7:0]             mem_rdata,
  input  wire logic                   mem_rvalid,
  input  wire bta_pkg::bta_iop_s      iop,
  output bta_pkg::bta_ires_s          ires
);

  // The struct layout is fixed at a 16-bit address space
  if (PC_W != `BTA_PC_W) begin : g_bad_width
    $error("bta_core supports only a 16-bit program counter");
  end

  bta_pkg::bta_core_s s;
  bta_pkg::bta_core_s next_s;

  logic [`BTA_PC_W-1:0] seq_addr;
  logic [`BTA_PC_W-1:0] rel_disp;
  logic [`BTA_PC_W-1:0] far_addr;
  logic [`BTA_PC_W-1:0] tbl_entry;
  logic                 take;

  // Start of the following instruction
  assign seq_addr = s.pc + {13'h0000, req.len};

  // Sign of the displacement copied through the upper byte
  assign rel_disp = {{8{req.relative_displacement[`BTA_DISP_W-1]}}, req.relative_displacement};

  // Short field low, bit 11 forced, top nibble clear
  assign far_addr = `BTA_FAR_BASE | {5'h00, req.short_call_field};

  // Even entry address; index from opcode bits 1 to 5
  assign tbl_entry = `BTA_TBL_BASE | {10'h000, req.opcode[5:1], 1'b0};

  // Accepted only while idle; a request during a table fetch is dropped
  assign take = req.valid && req_ready;

  // Next state: branch decision in idle, table fetch otherwise
  always_comb begin
    next_s = s;
    next_s.pc_load = 1'b0;
    case (s.state)
      bta_pkg::BTA_IDLE: begin
        if (take) begin
          next_s.pc_load = 1'b1;
          case (req.kind)
            bta_pkg::BTA_SEQ: begin
              next_s.pc = seq_addr;
            end
            bta_pkg::BTA_REL: begin
              // Carry out of bit 15 drops by the width of the sum
              next_s.pc = seq_addr + rel_disp;
            end
            bta_pkg::BTA_LONG: begin
              next_s.pc = req.imm;
            end
            bta_pkg::BTA_FAR: begin
              next_s.pc = far_addr;
            end
            bta_pkg::BTA_REG: begin
              next_s.pc = req.accumulator_pair;
            end
            bta_pkg::BTA_TBL: begin
              // PC holds its value until both entry bytes are in
              next_s.pc_load = 1'b0;
              next_s.tbl_addr = tbl_entry;
              next_s.state = bta_pkg::BTA_RD_LO;
            end
            default: begin
              next_s.pc_load = 1'b0;
            end
          endcase
        end
      end
      bta_pkg::BTA_RD_LO: begin
        if (mem_rvalid) begin
          next_s.lo_byte = mem_rdata;
          next_s.tbl_addr = s.tbl_addr | 16'h0001;
          next_s.state = bta_pkg::BTA_RD_HI;
        end
      end
      bta_pkg::BTA_RD_HI: begin
        if (mem_rvalid) begin
          next_s.pc = {mem_rdata, s.lo_byte};
          next_s.pc_load = 1'b1;
          next_s.state = bta_pkg::BTA_IDLE;
        end
      end
      default: begin
        next_s.state = bta_pkg::BTA_IDLE;
      end
    endcase
  end

  // Single register bank for all branch state
  always_ff @(posedge clk) begin
    if (rst) begin
      s.state <= bta_pkg::BTA_IDLE;
      s.pc <= RESET_PC;
      s.pc_load <= 1'b0;
      s.tbl_addr <= `BTA_TBL_BASE;
      s.lo_byte <= 8'h00;
    end else begin
      s <= next_s;
    end
  end

  // Handshake combinational, data straight from flops
  assign req_ready = (s.state == bta_pkg::BTA_IDLE);
  assign mem_rd = (s.state != bta_pkg::BTA_IDLE);
  assign mem_addr = s.tbl_addr;
  assign pc = s.pc;
  assign pc_load = s.pc_load;

  // Accumulator-implied arithmetic, registered one cycle
  bta_implied u_implied (
    .clk  (clk),
    .rst  (rst),
    .iop  (iop),
    .ires (ires)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Accepted request of one kind, for the cover points
  sequence s_kind(logic [2:0] k);
    take && req.kind == k;
  endsequence

  a_seq_advance: assert property (take && req.kind == bta_pkg::BTA_SEQ |=>
    pc_load && pc == 16'($past(pc) + $past(req.len)))
    else $error("sequential advance wrong");

  a_rel_target: assert property (take && req.kind == bta_pkg::BTA_REL |=>
    pc == 16'($past(pc) + $past(req.len) + $past(rel_disp)))
    else $error("relative target wrong");

  a_rel_signed: assert property (take && req.kind == bta_pkg::BTA_REL |=>
    $signed(16'(pc - $past(seq_addr))) == $signed($past(req.relative_displacement)))
    else $error("relative displacement not signed");

  a_rel_wrap: assert property (take && req.kind == bta_pkg::BTA_REL && s.pc == 16'hffff
    && req.len == 3'h2 && req.relative_displacement == 8'h00 |=> pc == 16'h0001)
    else $error("relative sum did not wrap");

  a_long_imm: assert property (take && req.kind == bta_pkg::BTA_LONG |=>
    pc_load && pc == $past(req.imm))
    else $error("long immediate not loaded");

  a_far_window: assert property (take && req.kind == bta_pkg::BTA_FAR |=>
    pc >= `BTA_FAR_BASE && pc <= `BTA_FAR_LAST && pc[10:0] == $past(req.short_call_field))
    else $error("fixed-area target outside window");

  a_tbl_range: assert property (mem_rd |->
    mem_addr >= `BTA_TBL_BASE && mem_addr <= `BTA_TBL_LAST)
    else $error("table read outside call table");

  a_tbl_index: assert property (take && req.kind == bta_pkg::BTA_TBL |=>
    mem_rd && !pc_load && mem_addr[5:1] == $past(req.opcode[5:1]) && !mem_addr[0])
    else $error("table index wrong");

  a_tbl_pair: assert property (mem_rd && !mem_addr[0] && mem_rvalid |=>
    mem_rd && mem_addr == 16'($past(mem_addr) + 16'h0001) && !pc_load)
    else $error("table entry bytes out of order");

  a_tbl_load: assert property (mem_rd && mem_addr[0] && mem_rvalid |=>
    pc_load && pc[15:8] == $past(mem_rdata) && !mem_rd)
    else $error("table entry not loaded");

  a_reg_jump: assert property (take && req.kind == bta_pkg::BTA_REG |=>
    pc_load && pc == $past(req.accumulator_pair))
    else $error("register jump wrong");

  a_pc_stable: assert property (!pc_load |-> pc == $past(pc))
    else $error("pc moved without load");

  // Sequential and relative forms: ready stays up, load pulses once
  a_seq_one_byte: assert property (take && req.kind == bta_pkg::BTA_SEQ
    && req.len == 3'h1
    |=> pc == 16'($past(pc) + 16'h0001))
    else $error("single-byte advance wrong");

  a_seq_ready: assert property (take && req.kind == bta_pkg::BTA_SEQ
    |=> pc_load && req_ready && !mem_rd)
    else $error("sequential advance left unit busy");

  a_rel_load: assert property (take && req.kind == bta_pkg::BTA_REL
    |=> pc_load && req_ready && !mem_rd)
    else $error("relative branch did not load");

  a_rel_zero: assert property (take && req.kind == bta_pkg::BTA_REL
    && req.relative_displacement == 8'h00
    |=> pc == $past(seq_addr))
    else $error("zero displacement missed next address");

  a_rel_fwd_edge: assert property (take && req.kind == bta_pkg::BTA_REL
    && req.relative_displacement == 8'h7f
    |=> pc == 16'($past(seq_addr) + 16'h007f))
    else $error("forward reach wrong");

  a_rel_back_edge: assert property (take && req.kind == bta_pkg::BTA_REL
    && req.relative_displacement == 8'h80
    |=> pc == 16'($past(seq_addr) - 16'h0080))
    else $error("backward reach wrong");

  // Immediate and register forms
  a_long_ready: assert property (take && req.kind == bta_pkg::BTA_LONG
    |=> req_ready && !mem_rd)
    else $error("long branch left unit busy");

  a_far_bits: assert property (take && req.kind == bta_pkg::BTA_FAR
    |=> pc[11] && pc[15:12] == 4'h0)
    else $error("fixed-area upper bits wrong");

  a_far_load: assert property (take && req.kind == bta_pkg::BTA_FAR
    |=> pc_load && req_ready && !mem_rd)
    else $error("fixed-area call did not load");

  a_reg_ready: assert property (take && req.kind == bta_pkg::BTA_REG
    |=> req_ready && !mem_rd)
    else $error("register jump left unit busy");

  // Table fetch: pc frozen, address held, low byte kept until the high one
  a_tbl_busy: assert property (mem_rd |-> !req_ready && !pc_load)
    else $error("unit ready during table fetch");

  a_ready_busy: assert property (!req_ready |-> mem_rd && !pc_load)
    else $error("unit busy outside table fetch");

  a_tbl_addr_hold: assert property (mem_rd && !mem_rvalid
    |=> mem_rd && mem_addr == $past(mem_addr))
    else $error("table address moved while waiting");

  a_tbl_pc_hold: assert property (mem_rd && !mem_rvalid
    |=> pc == $past(pc))
    else $error("pc moved during table fetch");

  a_tbl_even_start: assert property ($rose(mem_rd) |-> !mem_addr[0])
    else $error("table fetch began at odd address");

  a_tbl_word_range: assert property (mem_rd
    |-> mem_addr[15:7] == 9'h000 && mem_addr[6])
    else $error("table read above call table");

  a_tbl_lo_capture: assert property (mem_rd && !mem_addr[0] && mem_rvalid
    |=> s.lo_byte == $past(mem_rdata))
    else $error("low entry byte not kept");

  a_tbl_lo_first: assert property (mem_rd && mem_addr[0] && mem_rvalid
    |=> pc[7:0] == $past(s.lo_byte))
    else $error("low entry byte not placed low");

  a_tbl_return: assert property (mem_rd && mem_addr[0] && mem_rvalid
    |=> req_ready)
    else $error("unit not idle after table fetch");

  a_load_idle: assert property (pc_load |-> req_ready && !mem_rd)
    else $error("load while table fetch busy");

  // Main scenarios reached by the bench
  c_rel_back: cover property (take && req.kind == bta_pkg::BTA_REL && req.relative_displacement[7]);
  c_tbl_done: cover property (s_kind(bta_pkg::BTA_TBL) ##[1:20] pc_load);
  c_far: cover property (s_kind(bta_pkg::BTA_FAR));
  c_reg: cover property (s_kind(bta_pkg::BTA_REG) ##1 take);
  c_seq_rel: cover property (s_kind(bta_pkg::BTA_SEQ) ##1 s_kind(bta_pkg::BTA_REL));

endmodule : bta_core

//--- testbench/bta_core_tb.sv
// Self-checking bench for the branch target unit and its implied ops.
// Assumes bta_pkg and bta_core are compiled first; one 20 MHz clock.
`timescale 1ns/1ns
module bta_core_tb;
  localparam int LIMIT = 5000;
  logic                clk        = 1'b0;
  logic                rst        = 1'b1;
  bta_pkg::bta_req_s   req        = '0;
  bta_pkg::bta_iop_s   iop        = '0;
  logic [7:0]          mem_rdata  = 8'h00;
  logic                mem_rvalid = 1'b0;
  logic                req_ready;
  logic [15:0]         pc;
  logic                pc_load;
  logic                mem_rd;
  logic [15:0]         mem_addr;
  bta_pkg::bta_ires_s  ires;
  int                  err_count   = 0;
  int                  comparisons = 0;
  int                  seed        = 51;
  int                  cycles      = 0;
  logic                have_prev   = 1'b0;
  logic [15:0]         mpc         = 16'h0000;

  // 50 ns period
  always #25 clk = ~clk;

  bta_core uut (
    .clk        (clk),
    .rst        (rst),
    .req        (req),
    .req_ready  (req_ready),
    .pc         (pc),
    .pc_load    (pc_load),
    .mem_rd     (mem_rd),
    .mem_addr   (mem_addr),
    .mem_rdata  (mem_rdata),
    .mem_rvalid (mem_rvalid),
    .iop        (iop),
    .ires       (ires)
  );

  task finish_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h got %h", name, exp, got);
    end
  endtask : chk16

  task chk1(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %b got %b", name, exp, got);
    end
  endtask : chk1

  // Hang guard: a stuck handshake ends the run as a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      finish_test;
    end
  end

  // Reference next-pc; additions wrap at 16 bits on purpose
  function automatic logic [15:0] br_target(bta_pkg::bta_req_s r, logic [15:0] cur);
    case (r.kind)
      bta_pkg::BTA_REL:  return cur + 16'(r.len) + {{8{r.relative_displacement[7]}}, r.relative_displacement};
      bta_pkg::BTA_LONG: return r.imm;
      bta_pkg::BTA_FAR:  return {5'h01, r.short_call_field};
      bta_pkg::BTA_REG:  return r.accumulator_pair;
      default:           return cur + 16'(r.len);
    endcase
  endfunction : br_target

  // Random non-table request, lengths 1 to 4 bytes
  function automatic bta_pkg::bta_req_s rnd_req();
    bta_pkg::bta_req_s r;
    logic [2:0]        k;
    k = 3'(($random(seed) & 32'h7fffffff) % 5);
    r.valid = 1'b1;
    r.kind = bta_pkg::bta_kind_e'((k == 3'h4) ? 3'h5 : k);
    r.len = 3'(1 + ($random(seed) & 3));
    r.relative_displacement = 8'($random(seed));
    r.imm = 16'($random(seed));
    r.short_call_field = 11'($random(seed));
    r.opcode = 8'($random(seed));
    r.accumulator_pair = 16'($random(seed));
    return r;
  endfunction : rnd_req

  // Result of the previous request shows one edge after it was taken
  task check_prev;
    if (have_prev) begin
      chk16("pc", mpc, pc);
      chk1("pc_load", 1'b1, pc_load);
    end
  endtask : check_prev

  task br(input bta_pkg::bta_req_s r);
    req <= r;
    @(posedge clk);
    check_prev;
    mpc = br_target(r, mpc);
    have_prev = 1'b1;
  endtask : br

  task idle;
    req.valid <= 1'b0;
    @(posedge clk);
    check_prev;
    have_prev = 1'b0;
  endtask : idle

  // Table call with a slow memory; released data line shows the inverse
  task tbl(input logic [4:0] idx, input logic [15:0] tgt);
    bta_pkg::bta_req_s r;
    logic [15:0]       a;
    int                n;
    r = rnd_req();
    r.kind = bta_pkg::BTA_TBL;
    r.opcode[5:1] = idx;
    a = 16'h0040 | {10'h000, idx, 1'b0};
    req <= r;
    @(posedge clk);
    check_prev;
    have_prev = 1'b0;
    req.valid <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      repeat (1 + ($random(seed) & 3)) @(posedge clk);
      chk1("mem_rd", 1'b1, mem_rd);
      chk1("req_ready", 1'b0, req_ready);
      chk16("mem_addr", a + 16'(b), mem_addr);
      mem_rvalid <= 1'b1;
      mem_rdata <= (b == 1) ? tgt[15:8] : tgt[7:0];
      @(posedge clk);
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pc_load !== 1'b1 && n < 4);
    chk1("pc_load", 1'b1, pc_load);
    chk16("pc", tgt, pc);
    chk1("mem_rd", 1'b0, mem_rd);
    chk1("req_ready", 1'b1, req_ready);
    mpc = tgt;
  endtask : tbl

  // Reference for implied ops; pair is {A, X}
  function automatic bta_pkg::bta_ires_s imp_exp(bta_pkg::bta_iop_s q);
    bta_pkg::bta_ires_s e;
    logic [7:0]         a;
    a = q.accumulator_pair[15:8];
    e = '{valid: 1'b1, accumulator_pair: q.accumulator_pair, aux: q.mem_byte, cy: q.cy};
    case (q.op)
      bta_pkg::BTA_OP_MUL: e.accumulator_pair = 16'(a) * 16'(q.accumulator_pair[7:0]);
      bta_pkg::BTA_OP_DIV: begin
        e.accumulator_pair = (q.divisor == 8'h00) ? 16'hffff : q.accumulator_pair / 16'(q.divisor);
        e.aux = (q.divisor == 8'h00) ? q.accumulator_pair[7:0] : 8'(q.accumulator_pair % 16'(q.divisor));
      end
      bta_pkg::BTA_OP_ADJ_ADD: begin
        e.accumulator_pair[15:8] = a + ((a[3:0] > 4'h9 || q.ac) ? 8'h06 : 8'h00) + ((a > 8'h99 || q.cy) ? 8'h60 : 8'h00);
        e.cy = (a > 8'h99) || q.cy;
      end
      bta_pkg::BTA_OP_ADJ_SUB: e.accumulator_pair[15:8] = a - (q.ac ? 8'h06 : 8'h00) - (q.cy ? 8'h60 : 8'h00);
      bta_pkg::BTA_OP_DIG_LEFT: begin
        e.accumulator_pair[11:8] = q.mem_byte[7:4];
        e.aux = {q.mem_byte[3:0], a[3:0]};
      end
      default: begin
        e.accumulator_pair[11:8] = q.mem_byte[3:0];
        e.aux = {a[3:0], q.mem_byte[7:4]};
      end
    endcase
    return e;
  endfunction : imp_exp

  task imp(input bta_pkg::bta_op_e o, input logic [15:0] p, input logic [7:0] d, input logic c, input logic h);
    bta_pkg::bta_iop_s  q;
    bta_pkg::bta_ires_s e;
    q = '{valid: 1'b1, op: o, accumulator_pair: p, divisor: d, mem_byte: 8'($random(seed)), cy: c, ac: h};
    e = imp_exp(q);
    iop <= q;
    @(posedge clk);
    iop.valid <= 1'b0;
    @(posedge clk);
    chk1("ires_valid", 1'b1, ires.valid);
    chk16("ires_pair", e.accumulator_pair, ires.accumulator_pair);
    chk16("ires_aux", {8'h00, e.aux}, {8'h00, ires.aux});
    if (o == bta_pkg::BTA_OP_ADJ_ADD || o == bta_pkg::BTA_OP_ADJ_SUB) chk1("ires_cy", e.cy, ires.cy);
  endtask : imp

  // Main sequence: reset, branch corners, random mix, implied ops
  initial begin
    bta_pkg::bta_req_s r;
    bta_pkg::bta_op_e  o;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk16("pc", 16'h0000, pc);
    chk1("req_ready", 1'b1, req_ready);
    chk1("mem_rd", 1'b0, mem_rd);
    chk16("mem_addr", 16'h0040, mem_addr);
    r = rnd_req();
    r.kind = bta_pkg::BTA_LONG;
    r.imm = 16'hffff;
    br(r);
    r.kind = bta_pkg::BTA_REL;
    r.len = 3'h2;
    r.relative_displacement = 8'h00;
    br(r);
    r.kind = bta_pkg::BTA_LONG;
    r.imm = 16'hfffe;
    br(r);
    r.kind = bta_pkg::BTA_REL;
    r.len = 3'h2;
    r.relative_displacement = 8'h7f;
    br(r);
    r.kind = bta_pkg::BTA_LONG;
    r.imm = 16'h0010;
    br(r);
    r.kind = bta_pkg::BTA_REL;
    r.relative_displacement = 8'h80;
    br(r);
    r.kind = bta_pkg::BTA_FAR;
    r.short_call_field = 11'h7ff;
    br(r);
    r.short_call_field = 11'h000;
    br(r);
    idle;
    tbl(5'h00, 16'($random(seed)));
    tbl(5'h1f, 16'($random(seed)));
    for (int i = 0; i < 150; i++) begin
      if (($random(seed) & 7) == 0) tbl(5'($random(seed)), 16'($random(seed)));
      else if (($random(seed) & 7) == 0) idle;
      else br(rnd_req());
    end
    idle;
    imp(bta_pkg::BTA_OP_DIV, 16'h1234, 8'h00, 1'b0, 1'b0);
    imp(bta_pkg::BTA_OP_MUL, 16'hffff, 8'h00, 1'b0, 1'b0);
    imp(bta_pkg::BTA_OP_ADJ_ADD, 16'h5906, 8'h00, 1'b0, 1'b0);
    imp(bta_pkg::BTA_OP_ADJ_ADD, 16'h4b5a, 8'h00, 1'b0, 1'b0);
    imp(bta_pkg::BTA_OP_ADJ_ADD, 16'ha301, 8'h00, 1'b0, 1'b0);
    imp(bta_pkg::BTA_OP_ADJ_ADD, 16'h1202, 8'h00, 1'b0, 1'b1);
    imp(bta_pkg::BTA_OP_ADJ_ADD, 16'h3703, 8'h00, 1'b1, 1'b0);
    imp(bta_pkg::BTA_OP_ADJ_SUB, 16'h4504, 8'h00, 1'b0, 1'b1);
    imp(bta_pkg::BTA_OP_ADJ_SUB, 16'h9f05, 8'h00, 1'b1, 1'b1);
    for (int i = 0; i < 60; i++) begin
      o = bta_pkg::bta_op_e'((i % 3 == 2) ? 3'(4 + (i & 1)) : 3'(i % 3));
      imp(o, 16'($random(seed)), 8'($random(seed)), 1'($random(seed)), 1'b0);
    end
    finish_test;
  end
endmodule : bta_core_tb
